//--- logic/cht_pkg.sv
// Package: constants for the class H tracking signal generator
package cht_pkg;
  // Register byte offsets
  localparam logic [7:0] CHT_REG_CTRL = 8'h00;
  localparam logic [7:0] CHT_REG_GAIN = 8'h04;
  localparam logic [7:0] CHT_REG_STAT = 8'h08;
  localparam logic [7:0] CHT_REG_LEVEL = 8'h0c;
  // Control field positions
  localparam int CHT_OFS_LSB = 0;
  localparam int CHT_DLY_LSB = 4;
  localparam int CHT_MODE_BIT = 8;
  localparam int CHT_ISCALE_BIT = 9;
  // Reset values
  localparam logic [2:0] CHT_OFS_RST = 3'h0;
  localparam logic [3:0] CHT_DLY_RST = 4'h0;
  localparam logic [7:0] CHT_GAIN_RST = 8'h00;
  // Group delay range in microseconds and audio rate
  localparam int CHT_DLY_MIN_US = 100;
  localparam int CHT_DLY_MAX_US = 500;
  localparam int CHT_FS_HZ = 96000;
  // Delay in frames for the shortest setting, and per step
  localparam int CHT_DLY_MIN_FR = (CHT_DLY_MIN_US * CHT_FS_HZ) / 1000000;
  localparam int CHT_DLY_STEP_FR =
    ((CHT_DLY_MAX_US - CHT_DLY_MIN_US) * CHT_FS_HZ) / (15 * 1000000);
  // Gain code for unity; each step is about 0.4 dB
  localparam logic [7:0] CHT_GAIN_UNITY = 8'h0f;
  // Headroom steps in percent of full scale
  localparam int CHT_OFS_STEP_PCT = 2;
endpackage

//--- logic/cht_tracking_gen.sv
// Class H tracking reference generator with audio group delay
`timescale 1ns/100ps

// What this block does
// - Tracking signal is the per-frame maximum across up to 32 channels.
// - Add static headroom offset, percent of full scale, by 3-bit select.
// - Audio group delay from 9 to 39 stored beats, set by a 4-bit field.
// - Group delay applies to audio path only, never the tracking path.
// - Scale tracking by 8-bit gain, +6 dB to -6 dB, 0.4 dB steps.
// - Mode 0 references to zero; mode 1 references to full scale.
// - Inverted mode scale bit modifies the signal only in mode 1.
// - Finished tracking signal goes out to the reference DAC.
module cht_tracking_gen
  import cht_pkg::*;
#(
  parameter int DW = 24,
  parameter int CH = 32,
  parameter int DEPTH = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Audio sample stream, one channel per beat
  input wire logic s_valid_i,
  input wire logic [DW-1:0] s_data_i,
  input wire logic s_last_i,
  output logic s_ready_o,
  // Delayed audio stream toward audio DACs
  output logic a_valid_o,
  output logic [DW-1:0] a_data_o,
  output logic a_last_o,
  input wire logic a_ready_i,
  // Reference DAC sample, one per frame
  output logic [DW-1:0] ref_dac_o,
  output logic ref_valid_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [DW-1:0] FULL = {1'b0, {(DW-1){1'b1}}};
  // Highest gain code that still has a meaning: two octaves above zero
  localparam logic [7:0] GMAX = 8'(2 * int'(CHT_GAIN_UNITY));

  // State of the block apart from the delay memory, registered as one word
  typedef struct packed {
    // Bus answer
    logic ack;
    logic [31:0] rdat;
    // Software settings
    logic [2:0] headroom_offset_sel;
    logic [3:0] dly_sel;
    logic supply_reference_sel;
    logic inverted_mode_scale;
    logic [7:0] reference_path_gain;
    // Tracking path
    logic [DW-1:0] run_max;
    logic [DW-1:0] frame_max;
    logic [DW-1:0] ref_out;
    logic ref_vld;
    // Delay line pointers and output buffer
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [1:0] ocnt;
    logic [DW:0] ob0;
    logic [DW:0] ob1;
    // Input side may take a beat at the next edge
    logic rdy;
  } cht_state_s;

  cht_state_s st, next_st;
  logic [DW:0] mem [DEPTH];

  // Magnitude of a signed sample, saturating the most negative
  function automatic logic [DW-1:0] cht_mag(input logic [DW-1:0] v);
    logic [DW-1:0] n;
    n = '0;
    if (v[DW-1]) begin
      n = (~v) + {{(DW-1){1'b0}}, 1'b1};
      if (n[DW-1]) begin
        n = FULL;
      end
    end else begin
      n = v;
    end
    return n;
  endfunction

  // Saturate a wide unsigned value to positive full scale
  function automatic logic [DW-1:0] cht_sat(input logic [DW+8:0] v);
    logic [DW-1:0] r;
    r = (v > {9'h000, FULL}) ? FULL : v[DW-1:0];
    return r;
  endfunction

  // Approximate 0.4 dB steps: 15 codes per 6 dB, unity at code 15
  function automatic logic [DW+8:0] cht_gain(input logic [DW-1:0] v,
                                            input logic [7:0] g);
    logic [DW+8:0] x;
    logic [7:0] gc;
    logic [7:0] oct;
    logic [3:0] frac;
    // Codes past +6 dB are held there, so the shift below can never
    // carry the sample out of the wide word and wrap to a small value
    gc = (g > GMAX) ? GMAX : g;
    x = {9'h000, v};
    oct = gc / 8'd15;
    frac = 4'(gc % 8'd15);
    // Fractional step: x * (1 + frac/15) roughly matches 2^(frac/15)
    x = x + ((x * (DW+9)'(frac)) / (DW+9)'(15));
    x = x << 1;
    // Align so code 15 gives unity and lower codes attenuate
    x = (oct >= 8'd2) ? (x << (oct - 8'd2)) : (x >> (8'd2 - oct));
    return x;
  endfunction

  // Group delay in stored beats for a delay select, capped at DEPTH
  function automatic logic [PW-1:0] cht_dly(input logic [3:0] s);
    int d;
    d = CHT_DLY_MIN_FR + CHT_DLY_STEP_FR * int'(s);
    if (d > DEPTH) begin
      d = DEPTH;
    end
    return PW'(d);
  endfunction

  logic wr_fire, push, pop_mem, out_take, gap_ok;
  logic [PW-1:0] fill;
  logic [DW-1:0] mag, trk, hr;
  logic [DW+8:0] trk_w;

  // Handshakes of the delay line and output buffer
  always_comb begin
    fill = st.wptr - st.rptr;
    // Ready flop already says whether the memory has room
    push = s_valid_i && st.rdy;
    out_take = st.ocnt != 2'd0 && a_ready_i;
    gap_ok = (st.ocnt != 2'd2) || out_take;
    // Audio leaves only once the programmed lead has built up
    pop_mem = (fill > cht_dly(st.dly_sel)) && gap_ok;
    wr_fire = wb_cyc_i && wb_stb_i && !st.ack;
  end

  // Tracking arithmetic from the latched frame maximum
  always_comb begin
    mag = cht_mag(s_data_i);
    hr = DW'((FULL / DW'(100)) * DW'(CHT_OFS_STEP_PCT) *
         DW'(st.headroom_offset_sel));
    trk_w = cht_gain(st.frame_max, st.reference_path_gain) +
            {9'h000, hr};
    trk = cht_sat(trk_w);
    if (st.supply_reference_sel) begin
      // Referenced down from full scale; optional halved swing
      trk = st.inverted_mode_scale ? FULL - (trk >> 1) : FULL - trk;
    end
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.ack = wr_fire;
    next_st.ref_vld = 1'b0;
    // Writes land at the edge that takes the request
    if (wr_fire && wb_we_i) begin
      unique case (wb_adr_i)
        CHT_REG_CTRL: begin
          // Low lane carries the headroom and delay selects
          if (wb_sel_i[0]) begin
            next_st.headroom_offset_sel = wb_dat_i[CHT_OFS_LSB +: 3];
            next_st.dly_sel = wb_dat_i[CHT_DLY_LSB +: 4];
          end
          // Second lane carries the two mode bits
          if (wb_sel_i[1]) begin
            next_st.supply_reference_sel = wb_dat_i[CHT_MODE_BIT];
            next_st.inverted_mode_scale = wb_dat_i[CHT_ISCALE_BIT];
          end
        end
        CHT_REG_GAIN: begin
          if (wb_sel_i[0]) begin
            next_st.reference_path_gain = wb_dat_i[7:0];
          end
        end
        // Read-only or unmapped: the write is dropped
        default: begin
        end
      endcase
    end
    // Read data stands with ack for one cycle, zero otherwise
    next_st.rdat = '0;
    if (wr_fire && !wb_we_i) begin
      unique case (wb_adr_i)
        CHT_REG_CTRL: begin
          next_st.rdat[CHT_OFS_LSB +: 3] = st.headroom_offset_sel;
          next_st.rdat[CHT_DLY_LSB +: 4] = st.dly_sel;
          next_st.rdat[CHT_MODE_BIT] = st.supply_reference_sel;
          next_st.rdat[CHT_ISCALE_BIT] = st.inverted_mode_scale;
        end
        CHT_REG_GAIN: begin
          next_st.rdat[7:0] = st.reference_path_gain;
        end
        // Fill level of the delay memory
        CHT_REG_STAT: begin
          next_st.rdat[PW-1:0] = fill;
        end
        // Peak of the last complete frame
        CHT_REG_LEVEL: begin
          next_st.rdat[DW-1:0] = st.frame_max;
        end
        // Unmapped reads return zero
        default: begin
          next_st.rdat = '0;
        end
      endcase
    end
    // Running maximum over the frame's channels
    if (push) begin
      if (s_last_i) begin
        next_st.frame_max = (mag > st.run_max) ? mag : st.run_max;
        next_st.run_max = '0;
      end else if (mag > st.run_max) begin
        next_st.run_max = mag;
      end
      next_st.wptr = st.wptr + PW'(1);
    end
    // Tracking pulse leaves undelayed at each frame end
    if (push && s_last_i) begin
      next_st.ref_vld = 1'b1;
    end
    // Reference moves only in the cycle after the pulse, once the new
    // frame peak is latched; settings written between frames wait for
    // the next frame so the held level never jumps on its own
    if (st.ref_vld) begin
      next_st.ref_out = trk;
    end
    // Two-entry output buffer: the head shifts out on a take
    if (out_take) begin
      next_st.ob0 = st.ob1;
    end
    if (pop_mem) begin
      next_st.rptr = st.rptr + PW'(1);
      if (st.ocnt == 2'd0 || (st.ocnt == 2'd1 && out_take)) begin
        next_st.ob0 = mem[st.rptr[AW-1:0]];
      end else begin
        next_st.ob1 = mem[st.rptr[AW-1:0]];
      end
    end
    next_st.ocnt = st.ocnt + 2'(pop_mem) - 2'(out_take);
    // Room for the next edge, held in a flop so the pin is registered
    next_st.rdy = (next_st.wptr - next_st.rptr) != PW'(DEPTH);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.headroom_offset_sel <= CHT_OFS_RST;
      st.dly_sel <= CHT_DLY_RST;
      st.reference_path_gain <= CHT_GAIN_RST;
      // Memory is empty after reset, so beats may come at once
      st.rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Delay memory; contents need no reset, the pointers guard them
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[st.wptr[AW-1:0]] <= {s_last_i, s_data_i};
    end
  end

  // Outputs straight from state
  always_comb begin
    // Bus answer
    wb_ack_o = st.ack;
    wb_dat_o = st.rdat;
    // Audio stream, both sides
    s_ready_o = st.rdy;
    a_valid_o = st.ocnt != 2'd0;
    a_data_o = st.ob0[DW-1:0];
    a_last_o = st.ob0[DW];
    // Reference DAC sample and its strobe
    ref_dac_o = st.ref_out;
    ref_valid_o = st.ref_vld;
  end

endmodule // cht_tracking_gen

//--- bench/cht_tracking_gen_checker.sv
// Port assertions for the tracking generator
`timescale 1ns/100ps
module cht_tracking_gen_checker
  import cht_pkg::*;
#(
  parameter int DW = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic s_valid_i,
  input wire logic s_last_i,
  input wire logic s_ready_o,
  input wire logic a_valid_o,
  input wire logic [DW-1:0] a_data_o,
  input wire logic a_last_o,
  input wire logic a_ready_i,
  input wire logic [DW-1:0] ref_dac_o,
  input wire logic ref_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken, and address outside the map
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic unmap = !(wb_adr_i inside
    {CHT_REG_CTRL, CHT_REG_GAIN, CHT_REG_STAT, CHT_REG_LEVEL});
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  a_unmap_zero: assert property (wb_ack_o && !wb_we_i && unmap
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_out_hold: assert property (a_valid_o && !a_ready_i |=> a_valid_o
    && $stable(a_data_o) && $stable(a_last_o)) else $error("word lost");
  a_ref_frame: assert property (s_valid_i && s_ready_o && s_last_i
    |=> ref_valid_o) else $error("no reference after frame");
  a_ref_single: assert property (ref_valid_o |=> !ref_valid_o)
    else $error("reference pulse long");
  a_ref_steady: assert property (!$past(ref_valid_o)
    |-> $stable(ref_dac_o)) else $error("reference moved");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o
    && !a_valid_o && !ref_valid_o && ref_dac_o == '0)
    else $error("outputs busy after reset");
  // Main scenarios
  c_write: cover property (req && wb_we_i);
  c_stall: cover property (a_valid_o && !a_ready_i);
  c_ref: cover property (ref_valid_o);
  c_full: cover property (!s_ready_o);
endmodule // cht_tracking_gen_checker

bind cht_tracking_gen cht_tracking_gen_checker #(.DW(DW)) chk_u (.*);

//--- bench/cht_dac_sink.sv
// Audio DAC side model: takes delayed words, stalls on command
`timescale 1ns/100ps
module cht_dac_sink #(
  parameter int DW = 24
) (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic a_valid_i,
  input wire logic [DW-1:0] a_data_i,
  input wire logic a_last_i,
  output logic a_ready_o
);
  logic [DW-1:0] got[$];
  logic lst[$];
  // Ready unless told to stall
  assign a_ready_o = !hold_i;
  // Keep every accepted word in order
  always @(posedge clk_i) begin
    if (a_valid_i && a_ready_o) begin
      got.push_back(a_data_i);
      lst.push_back(a_last_i);
    end
  end
endmodule // cht_dac_sink

//--- bench/tb_cht_tracking_gen.sv
// Self-checking bench for the tracking generator
`timescale 1ns/100ps
module tb_cht_tracking_gen;
  import cht_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cht_row_s;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic s_valid = 0, s_last = 0, hold = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic [23:0] s_data = 24'h0, k, a_data, ref_dac, r[5];
  logic ack, s_ready, a_valid, a_last, ref_valid, a_ready;
  logic [23:0] sent[$];
  logic [9:0] cm[5] = '{10'h000, 10'h100, 10'h300, 10'h007, 10'h000};
  logic [7:0] gm[5] = '{8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h00};
  cht_row_s rows[3] = '{'{CHT_REG_CTRL, 32'h3f7, 32'h3f7},
    '{CHT_REG_GAIN, 32'hab, 32'hab}, '{8'h10, 32'hffffffff, 32'h0}};
  int fail_count = 0, total_checks = 0, cycles = 0;
  cht_tracking_gen #(.DW(24), .CH(32), .DEPTH(64)) dut_u (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat),
    .wb_ack_o(ack), .s_valid_i(s_valid), .s_data_i(s_data),
    .s_last_i(s_last), .s_ready_o(s_ready), .a_valid_o(a_valid),
    .a_data_o(a_data), .a_last_o(a_last), .a_ready_i(a_ready),
    .ref_dac_o(ref_dac), .ref_valid_o(ref_valid));
  cht_dac_sink #(.DW(24)) sink_u (.clk_i(clk_i), .hold_i(hold),
    .a_valid_i(a_valid), .a_data_i(a_data), .a_last_i(a_last),
    .a_ready_o(a_ready));
  // Clock and hang guard
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (++cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_smp(input logic [23:0] g, input logic [23:0] e);
    chk_reg({8'h0, g}, {8'h0, e});
  endtask
  // Single Wishbone cycle, answer taken at the ack edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask
  // One beat, held until taken
  task automatic send(input logic [23:0] d, input logic l);
    s_valid <= 1;
    s_data <= d;
    s_last <= l;
    do @(posedge clk_i); while (s_ready !== 1'b1);
    sent.push_back(d);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    foreach (rows[i]) begin
      wb(rows[i].a, 1, rows[i].d);
      wb(rows[i].a, 0, 32'h0);
      chk_reg(q, rows[i].e);
    end
    $display("test registers done");
    // Mode and gain settings, then a frame with a negative peak
    foreach (cm[i]) begin
      wb(CHT_REG_CTRL, 1, {22'h0, cm[i]});
      wb(CHT_REG_GAIN, 1, {24'h0, gm[i]});
      send(24'h100000, 0);
      send(24'h900000, 0);
      send(24'h200000, 1);
      s_valid <= 0;
      repeat (4) @(posedge clk_i);
      r[i] = ref_dac;
      if (i == 0) chk_reg({31'h0, a_valid}, 32'h0);
    end
    wb(CHT_REG_LEVEL, 0, 32'h0);
    chk_reg(q, 32'h700000);
    chk_smp(r[0], 24'h700000);
    chk_reg({31'h0, r[1] < r[0]}, 32'h1);
    chk_reg({31'h0, r[2] !== r[1]}, 32'h1);
    chk_reg({31'h0, r[3] > r[0]}, 32'h1);
    chk_reg({31'h0, r[4] < r[0]}, 32'h1);
    $display("test tracking done");
    // Fill while the DAC side stalls, then drain
    hold <= 1;
    s_valid <= 1;
    s_last <= 0;
    k = 24'h000100;
    repeat (100) begin
      s_data <= k;
      @(posedge clk_i);
      if (s_ready === 1'b1) begin
        sent.push_back(k);
        k++;
      end
    end
    chk_reg({31'h0, s_ready}, 32'h0);
    s_valid <= 0;
    hold <= 0;
    repeat (100) @(posedge clk_i);
    chk_reg({31'h0, s_ready}, 32'h1);
    foreach (sink_u.got[i]) chk_smp(sink_u.got[i], sent[i]);
    chk_reg(sent.size() - sink_u.got.size(), CHT_DLY_MIN_FR);
    for (int i = 0; i < 15; i++) begin
      chk_reg({31'h0, sink_u.lst[i]}, {31'h0, i % 3 == 2});
    end
    $display("test buffer done");
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(CHT_REG_CTRL, 0, 32'h0);
    chk_reg(q, 32'h0);
    wb(CHT_REG_GAIN, 0, 32'h0);
    chk_reg(q, {24'h0, CHT_GAIN_RST});
    $display("test reset done");
    test_done();
  end
endmodule // tb_cht_tracking_gen
